// ==== hw/aie_alu.sv ====
// Combinational 8-bit add/and unit with flag generation
// Assumes operands are stable for the whole processing phase
`timescale 1ns/10ps
`include "aie_cfg.svh"
module aie_alu (
   input  wire logic [7:0] a_i,
   input  wire logic [7:0] b_i,
   input  wire logic       cin_i,
   input  wire logic       is_and_i,
   output logic      [7:0] res_o,
   output logic            n_o,
   output logic            ov_o,
   output logic            c_o,
   output logic            dc_o,
   output logic            z_o
);
   logic [8:0] sum;
   logic [4:0] low;
   always_comb begin
      sum  = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
      low  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
      res_o = is_and_i ? (a_i & b_i) : sum[7:0];
      n_o  = res_o[7];
      z_o  = (res_o == 8'h00);
      c_o  = sum[8];
      dc_o = low[4];
      ov_o = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
   end
endmodule // aie_alu

// ==== hw/aie_cfg.svh ====
// Encodings, field positions and phase counts of the add/and datapath
// Assumes 16-bit instruction words and 8-bit data
`ifndef AIE_CFG_SVH
`define AIE_CFG_SVH
`define AIE_OP_ADD_LIT    8'h0f
`define AIE_OP_AND_LIT    8'h0b
`define AIE_OP6_ADD_FILE  6'h09
`define AIE_OP6_ADD_CARRY 6'h08
`define AIE_OP6_AND_FILE  6'h05
`define AIE_DEST_BIT      9
`define AIE_BANK_BIT      8
`define AIE_ACCESS_SPLIT  8'h80
`define AIE_ACCESS_HI     4'hf
`define AIE_ACCESS_LO     4'h0
`define AIE_PHASES        4
`endif

// ==== hw/aie_exec.sv ====
// Execution datapath for add and and instructions, four phases each
// Assumes data memory reads combinationally from file_addr_o
`timescale 1ns/10ps
`include "aie_cfg.svh"
module aie_exec (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        instr_valid_i,
   input  wire logic [15:0] instr_i,
   input  wire logic [3:0]  bank_pointer_i,
   input  wire logic [7:0]  file_rdata_i,
   output logic             instr_ready_o,
   output logic      [11:0] file_addr_o,
   output logic             file_we_o,
   output logic      [7:0]  file_wdata_o,
   output logic      [7:0]  wreg_o,
   output logic      [4:0]  status_o,
   output logic             done_o
);
   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef struct packed {
      aie_pkg::aie_phase_t phase;
      aie_pkg::aie_op_t    op;
      logic [15:0]         instr;
      logic [7:0]          opb;
      logic [7:0]          res;
      logic [4:0]          flg_nxt;
      logic [11:0]         addr;
      logic                we;
      logic [7:0]          wdata;
      logic [7:0]          wreg;
      logic [4:0]          status;
      logic                ready;
      logic                done;
   } aie_state_t;
   // status bits: {n, ov, z, dc, c}
   aie_state_t st_r;
   aie_state_t st_nxt;
   logic [7:0] alu_res;
   logic       f_n, f_ov, f_c, f_dc, f_z;
   logic       is_and, is_lit;
   assign is_and = (st_r.op == aie_pkg::AIE_OP_AND_LIT) ||
                   (st_r.op == aie_pkg::AIE_OP_AND_FILE);
   assign is_lit = (st_r.op == aie_pkg::AIE_OP_AND_LIT) ||
                   (st_r.op == aie_pkg::AIE_OP_ADD_LIT);
   aie_alu u_alu (
      .a_i      (st_r.wreg),
      .b_i      (st_r.opb),
      .cin_i    ((st_r.op == aie_pkg::AIE_OP_ADD_CARRY) & st_r.status[0]),
      .is_and_i (is_and),
      .res_o    (alu_res),
      .n_o      (f_n),
      .ov_o     (f_ov),
      .c_o      (f_c),
      .dc_o     (f_dc),
      .z_o      (f_z)
   );
   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb begin
      st_nxt       = st_r;
      st_nxt.we    = 1'b0;
      st_nxt.done  = 1'b0;
      unique case (st_r.phase)
         aie_pkg::AIE_PH_DECODE: begin
            st_nxt.ready = 1'b1;
            if (st_r.ready && instr_valid_i) begin
               st_nxt.ready = 1'b0;
               st_nxt.instr = instr_i;
               st_nxt.op    = aie_pkg::AIE_OP_NONE;
               if (instr_i[15:8] == `AIE_OP_ADD_LIT)
                  st_nxt.op = aie_pkg::AIE_OP_ADD_LIT;
               else if (instr_i[15:8] == `AIE_OP_AND_LIT)
                  st_nxt.op = aie_pkg::AIE_OP_AND_LIT;
               else if (instr_i[15:10] == `AIE_OP6_ADD_FILE)
                  st_nxt.op = aie_pkg::AIE_OP_ADD_FILE;
               else if (instr_i[15:10] == `AIE_OP6_ADD_CARRY)
                  st_nxt.op = aie_pkg::AIE_OP_ADD_CARRY;
               else if (instr_i[15:10] == `AIE_OP6_AND_FILE)
                  st_nxt.op = aie_pkg::AIE_OP_AND_FILE;
               // Access bank splits low and high halves
               if (instr_i[`AIE_BANK_BIT])
                  st_nxt.addr = {bank_pointer_i, instr_i[7:0]};
               else if (instr_i[7:0] < `AIE_ACCESS_SPLIT)
                  st_nxt.addr = {`AIE_ACCESS_LO, instr_i[7:0]};
               else
                  st_nxt.addr = {`AIE_ACCESS_HI, instr_i[7:0]};
               st_nxt.phase = aie_pkg::AIE_PH_READ;
            end
         end
         aie_pkg::AIE_PH_READ: begin
            st_nxt.opb   = is_lit ? st_r.instr[7:0] : file_rdata_i;
            st_nxt.phase = aie_pkg::AIE_PH_PROCESS;
         end
         aie_pkg::AIE_PH_PROCESS: begin
            st_nxt.res     = alu_res;
            st_nxt.flg_nxt = st_r.status;
            if (is_and) begin
               st_nxt.flg_nxt[4] = f_n;
               st_nxt.flg_nxt[2] = f_z;
            end else begin
               st_nxt.flg_nxt = {f_n, f_ov, f_z, f_dc, f_c};
            end
            st_nxt.phase = aie_pkg::AIE_PH_WRITE;
         end
         aie_pkg::AIE_PH_WRITE: begin
            if (st_r.op != aie_pkg::AIE_OP_NONE) begin
               st_nxt.status = st_r.flg_nxt;
               if (is_lit || !st_r.instr[`AIE_DEST_BIT]) begin
                  st_nxt.wreg = st_r.res;
               end else begin
                  st_nxt.we    = 1'b1;
                  st_nxt.wdata = st_r.res;
               end
            end
            st_nxt.done  = 1'b1;
            st_nxt.ready = 1'b1;
            st_nxt.phase = aie_pkg::AIE_PH_DECODE;
         end
      endcase
   end
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
   assign instr_ready_o = st_r.ready;
   assign file_addr_o   = st_r.addr;
   assign file_we_o     = st_r.we;
   assign file_wdata_o  = st_r.wdata;
   assign wreg_o        = st_r.wreg;
   assign status_o      = st_r.status;
   assign done_o        = st_r.done;
   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   property p_phase_seq;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_r.phase == aie_pkg::AIE_PH_DECODE && st_r.ready && instr_valid_i)
      |=> ##2 done_o == 1'b0 ##1 done_o;
   endproperty
   a_phase_seq: assert property (p_phase_seq)
      else $error("Instruction did not finish in four phases");
   property p_and_lit;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_r.ready && instr_valid_i && instr_i[15:8] == `AIE_OP_AND_LIT)
      |-> ##4 wreg_o == ($past(wreg_o, 4) & $past(instr_i[7:0], 4));
   endproperty
   a_and_lit: assert property (p_and_lit)
      else $error("And literal result wrong");
   property p_and_flags;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (done_o && $past(is_and))
      |-> status_o[3] == $past(status_o[3]) && status_o[1:0] ==
          $past(status_o[1:0]);
   endproperty
   a_and_flags: assert property (p_and_flags)
      else $error("And changed arithmetic flags");
   property p_add_lit;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_r.ready && instr_valid_i && instr_i[15:8] == `AIE_OP_ADD_LIT)
      |-> ##4 wreg_o == 8'($past(wreg_o, 4) + $past(instr_i[7:0], 4));
   endproperty
   a_add_lit: assert property (p_add_lit)
      else $error("Add literal result wrong");
   property p_dest_w;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_r.phase == aie_pkg::AIE_PH_WRITE && !is_lit &&
       st_r.op != aie_pkg::AIE_OP_NONE && !st_r.instr[`AIE_DEST_BIT])
      |=> !file_we_o && wreg_o == $past(st_r.res);
   endproperty
   a_dest_w: assert property (p_dest_w)
      else $error("Destination zero did not write working register");
   property p_dest_f;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_r.phase == aie_pkg::AIE_PH_WRITE && !is_lit &&
       st_r.op != aie_pkg::AIE_OP_NONE && st_r.instr[`AIE_DEST_BIT])
      |=> file_we_o && file_wdata_o == $past(st_r.res) && $stable(wreg_o);
   endproperty
   a_dest_f: assert property (p_dest_f)
      else $error("Destination one did not write file register");
   property p_bank;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_r.ready && instr_valid_i && instr_i[`AIE_BANK_BIT])
      |=> file_addr_o == {$past(bank_pointer_i), $past(instr_i[7:0])};
   endproperty
   a_bank: assert property (p_bank)
      else $error("Bank pointer address wrong");
   property p_carry;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_r.phase == aie_pkg::AIE_PH_PROCESS &&
       st_r.op == aie_pkg::AIE_OP_ADD_CARRY)
      |=> st_r.res == 8'(st_r.wreg + $past(st_r.opb) + $past(st_r.status[0]));
   endproperty
   a_carry: assert property (p_carry)
      else $error("Add with carry sum wrong");
   property p_add_file;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_r.phase == aie_pkg::AIE_PH_PROCESS &&
       st_r.op == aie_pkg::AIE_OP_ADD_FILE)
      |=> st_r.res == 8'($past(st_r.wreg) + $past(st_r.opb));
   endproperty
   a_add_file: assert property (p_add_file)
      else $error("Add to file sum wrong");
   property p_and_file;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_r.phase == aie_pkg::AIE_PH_PROCESS &&
       st_r.op == aie_pkg::AIE_OP_AND_FILE)
      |=> st_r.res == ($past(st_r.wreg) & $past(st_r.opb));
   endproperty
   a_and_file: assert property (p_and_file)
      else $error("And with file result wrong");
endmodule // aie_exec

// ==== hw/aie_pkg.sv ====
// Types shared by the add/and datapath files
// Assumes aie_cfg.svh is included where constants are needed
package aie_pkg;
   typedef enum logic [1:0] {
      AIE_PH_DECODE  = 2'b00,
      AIE_PH_READ    = 2'b01,
      AIE_PH_PROCESS = 2'b10,
      AIE_PH_WRITE   = 2'b11
   } aie_phase_t;
   typedef enum logic [2:0] {
      AIE_OP_NONE      = 3'b000,
      AIE_OP_ADD_LIT   = 3'b001,
      AIE_OP_AND_LIT   = 3'b010,
      AIE_OP_ADD_FILE  = 3'b011,
      AIE_OP_ADD_CARRY = 3'b100,
      AIE_OP_AND_FILE  = 3'b101
   } aie_op_t;
endpackage

// ==== tb/add_and_instruction_execute_tb.sv ====
// Self-checking bench for the add/and execution datapath
// Assumes aie_exec as top; data memory is an address function
`timescale 1ns/10ps
module add_and_instruction_execute_tb;
   logic        core_clk_i;
   logic        rst_n_i;
   logic        instr_valid_i;
   logic [15:0] instr_i;
   logic [3:0]  bank_pointer_i;
   logic [7:0]  file_rdata_i;
   logic        instr_ready_o;
   logic [11:0] file_addr_o;
   logic        file_we_o;
   logic [7:0]  file_wdata_o;
   logic [7:0]  wreg_o;
   logic [4:0]  status_o;
   logic        done_o;
   logic [7:0]  ew;
   logic [4:0]  est;
   int          failures;
   int          check_count;
   // Rows: {bank pointer, instruction word}
   logic [19:0] rows [14] = '{20'h00f10, 20'h00f15, 20'h00f7e, 20'h00b5f,
      20'h02410, 20'h32785, 20'h02090, 20'h00fff, 20'ha23c4, 20'h01433,
      20'h51777, 20'h00e55, 20'h00b00, 20'h02290};

   // Memory content is a fixed function of the address
   assign file_rdata_i = file_addr_o[7:0] ^ {file_addr_o[11:8], 4'ha};

   aie_exec uut (
      .core_clk_i     (core_clk_i),
      .rst_n_i        (rst_n_i),
      .instr_valid_i  (instr_valid_i),
      .instr_i        (instr_i),
      .bank_pointer_i (bank_pointer_i),
      .file_rdata_i   (file_rdata_i),
      .instr_ready_o  (instr_ready_o),
      .file_addr_o    (file_addr_o),
      .file_we_o      (file_we_o),
      .file_wdata_o   (file_wdata_o),
      .wreg_o         (wreg_o),
      .status_o       (status_o),
      .done_o         (done_o)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("checks=%0d mismatches=%0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic do_reset;
      @(posedge core_clk_i);
      rst_n_i <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      #1;
      check(wreg_o, 16'h0000);
      check(status_o, 16'h0000);
      check(instr_ready_o, 16'h0000);
      check(done_o, 16'h0000);
      check(file_we_o, 16'h0000);
      ew = 8'h00;
      est = 5'h00;
      @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      $display("test reset done");
   endtask

   task automatic run(input logic [19:0] row, input logic busy_offer);
      logic [11:0] a;
      logic [7:0]  b;
      logic [7:0]  r;
      logic [5:0]  op6;
      logic        lit, known, isand, co, dc, cin, wf;
      int          n;
      n = 0;
      while (instr_ready_o !== 1'b1 && n < 20) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      @(posedge core_clk_i);
      instr_valid_i  <= 1'b1;
      instr_i        <= row[15:0];
      bank_pointer_i <= row[19:16];
      @(posedge core_clk_i);
      instr_valid_i  <= 1'b0;
      instr_i        <= ~row[15:0];
      bank_pointer_i <= ~row[19:16];
      lit = (row[15:8] == 8'h0f) || (row[15:8] == 8'h0b);
      op6 = row[15:10];
      known = lit || op6 == 6'h09 || op6 == 6'h08 || op6 == 6'h05;
      isand = (row[15:8] == 8'h0b) || (op6 == 6'h05);
      wf = !lit && row[9];
      if (row[8])
         a = {row[19:16], row[7:0]};
      else
         a = {{4{row[7]}}, row[7:0]};
      b = lit ? row[7:0] : (a[7:0] ^ {a[11:8], 4'ha});
      cin = (op6 == 6'h08) ? est[0] : 1'b0;
      {co, r} = {1'b0, ew} + {1'b0, b} + {8'h00, cin};
      dc = ({1'b0, ew[3:0]} + {1'b0, b[3:0]} + {4'h0, cin}) > 5'h0f;
      if (isand)
         r = ew & b;
      if (known) begin
         if (isand)
            est = {r[7], est[3], r == 8'h00, est[1], est[0]};
         else
            est = {r[7], (ew[7] == b[7]) && (r[7] != ew[7]),
                   r == 8'h00, dc, co};
         if (!wf)
            ew = r;
      end
      // Take edge ends decode; read, process, write follow
      for (int k = 1; k <= 3; k++) begin
         @(posedge core_clk_i);
         instr_valid_i <= busy_offer && k < 3;
         #1;
         check(done_o, 16'(k == 3));
         check(instr_ready_o, 16'(k == 3));
         if (k < 3)
            check(file_we_o, 16'h0000);
      end
      check(wreg_o, ew);
      check(status_o, est);
      check(file_we_o, 16'(known && wf));
      if (known && wf)
         check(file_wdata_o, r);
      if (known && !lit)
         check(file_addr_o, a);
      @(posedge core_clk_i);
      #1;
      check(file_we_o, 16'h0000);
      check(done_o, 16'h0000);
      $display("test %h done", row[15:0]);
   endtask

   // ---------------------------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      rst_n_i        = 1'b0;
      instr_valid_i  = 1'b0;
      instr_i        = 16'h0000;
      bank_pointer_i = 4'h0;
      failures       = 0;
      check_count    = 0;
      do_reset;
      foreach (rows[i]) begin
         run(rows[i], 1'b0);
      end
      // Offers while busy must be ignored
      run(20'h72681, 1'b1);
      // Reset in mid-instruction
      @(posedge core_clk_i);
      instr_valid_i <= 1'b1;
      instr_i       <= 16'h0f7f;
      repeat (2) @(posedge core_clk_i);
      instr_valid_i <= 1'b0;
      do_reset;
      run(20'h00f80, 1'b0);
      results;
   end

   initial begin
      #20000;
      failures++;
      $display("watchdog expired");
      results;
   end
endmodule // add_and_instruction_execute_tb
